// *** rtl/tse_pkg.sv ***
// tse_pkg: register map, field positions, reset values, timing and carriers
// for the thermal sensor event logic.
// assumes a byte-wide configuration access port and an 8 ns core clock.
package tse_pkg;

  // byte offsets in the configuration window
  localparam logic [7:0] ADDR_SENSOR_OUT   = 8'hE0;
  localparam logic [7:0] ADDR_SENSOR_OUT_H = 8'hE1;
  localparam logic [7:0] ADDR_LOW_THR      = 8'hE2;
  localparam logic [7:0] ADDR_HIGH_THR     = 8'hE3;
  localparam logic [7:0] ADDR_LOW_STS_B0   = 8'hE4;
  localparam logic [7:0] ADDR_LOW_STS_B1   = 8'hE5;
  localparam logic [7:0] ADDR_HIGH_STS_B0  = 8'hE6;
  localparam logic [7:0] ADDR_HIGH_STS_B1  = 8'hE7;
  localparam logic [7:0] ADDR_EVENT_MASK   = 8'hE8;
  localparam logic [7:0] ADDR_EVENT_ROUTE  = 8'hE9;
  localparam logic [7:0] ADDR_SENSOR_CTRL  = 8'hEA;

  // field positions
  localparam int FLAG_BIT       = 8;
  localparam int FLAG_BYTE_BIT  = FLAG_BIT - 8;
  localparam int MASK_LOW_BIT   = 1;
  localparam int MASK_HIGH_BIT  = 0;
  localparam int CTRL_EN_BIT    = 1;
  localparam int CTRL_EVLOG_BIT = 0;
  localparam int CTRL_LATCH_BIT = 2;
  localparam int ROUTE_LSB      = 0;

  // reset values
  localparam logic [7:0] LOW_THR_RST  = 8'hB4;
  localparam logic [7:0] HIGH_THR_RST = 8'hC8;
  localparam logic [1:0] ROUTE_RST    = 2'h0;
  localparam logic [1:0] ROUTE_RSVD   = 2'h3;
  localparam logic [2:0] PINS_IDLE    = 3'h7;
  localparam logic [7:0] BYTE_ZERO    = 8'h00;

  // timing
  localparam int CLK_PERIOD_NS  = 8;
  localparam int INTERVAL_MS    = 125;
  localparam int INTERVAL_CYC   = INTERVAL_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CNT_W          = 24;
  localparam logic [CNT_W-1:0] FIRST_WIN_CYC = 24'h00_1000;
  localparam logic [CNT_W-1:0] RUN_WIN_CYC   = 24'h00_0040;
  localparam logic [CNT_W-1:0] CNT_ZERO      = 24'h00_0000;
  localparam logic [CNT_W-1:0] CNT_ONE       = 24'h00_0001;

  typedef enum logic [1:0] {
    TSE_SCH_OFF   = 2'b00,
    TSE_SCH_FIRST = 2'b01,
    TSE_SCH_RUN   = 2'b10
  } tse_sch_e;

  typedef struct packed {
    logic       req;
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tse_cfg_req_s;

  typedef struct packed {
    logic       rvalid;
    logic [7:0] rdata;
  } tse_cfg_rsp_s;

  // state kept through hard reset, cleared only at power-on
  typedef struct packed {
    logic       sensor_enable;
    logic       low_event_flag;
    logic [7:0] low_event_temperature;
    logic       high_event_flag;
    logic [7:0] high_event_temperature;
  } tse_sticky_s;

  // state cleared by hard reset
  typedef struct packed {
    logic [7:0]     sensor_output_value;
    logic           sample_valid;
    logic [7:0]     low_threshold;
    logic [7:0]     high_threshold;
    logic           low_event_mask;
    logic           high_event_mask;
    logic [1:0]     event_pin_select;
    logic           event_logic_enable;
    logic           latch_enable;
    tse_sch_e       sch;
    logic [CNT_W-1:0] cnt;
    logic           conv_active;
    logic [2:0]     err_n;
    tse_cfg_rsp_s   rsp;
  } tse_core_s;

  localparam tse_sticky_s STICKY_RST = '{
    sensor_enable: 1'b0, low_event_flag: 1'b0, low_event_temperature: BYTE_ZERO,
    high_event_flag: 1'b0, high_event_temperature: BYTE_ZERO};

  localparam tse_core_s CORE_RST = '{
    sensor_output_value: BYTE_ZERO, sample_valid: 1'b0,
    low_threshold: LOW_THR_RST, high_threshold: HIGH_THR_RST,
    low_event_mask: 1'b0, high_event_mask: 1'b0, event_pin_select: ROUTE_RST,
    event_logic_enable: 1'b0, latch_enable: 1'b0, sch: TSE_SCH_OFF,
    cnt: CNT_ZERO, conv_active: 1'b0, err_n: PINS_IDLE,
    rsp: '{rvalid: 1'b0, rdata: BYTE_ZERO}};

endpackage

// *** rtl/tse_thermal_event.sv ***
// tse_thermal_event: converter schedule, sample latch, threshold events,
// sticky status, masking and steering onto three active-low error pins.
// assumes the converter code is synchronous to clk and a separate power-on
// reset clears the sticky state; rstn is the hard reset.
//
// Summary of operation
// - enabled event logic sets the low flag when a sample crosses the low threshold
// - low event records the current 8-bit sensor reading as low temperature
// - a high threshold crossing sets the high event flag
// - high event records the current sensor reading as high temperature
// - a repeat crossing before clearing overwrites the recorded temperature
// - flags and temperatures survive hard reset; write one clears, zero ignored
// - low mask set blocks low events from the error pin only
// - high mask set blocks high events from the error pin only
// - masks never stop flag or temperature updates
// - steering 00/01/10 picks error pin 0/1/2, 11 drives none
// - low and high events share the one steered pin
// - sensor disabled stops conversion and freezes the output register
// - while enabled, the readout is latched every clock the converter runs
// - first interval runs 4096 clocks, then 64 clocks every 125 ms
// - sensor enable resets to zero and survives hard reset
// - event logic enable zero means no status events are raised
// - sensor output holds 8 bits at half a degree per count
// - low threshold resets to B4h and is writable
// - high threshold resets to C8h and is writable
`timescale 1ns/100ps
module tse_thermal_event #(
  parameter int INTERVAL_CYCLES = tse_pkg::INTERVAL_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 por_n,
  input  wire logic                 ce,
  input  wire tse_pkg::tse_cfg_req_s cfg_req,
  output tse_pkg::tse_cfg_rsp_s     cfg_rsp,
  input  wire logic [7:0]           adc_code,
  output logic                      conv_active,
  output logic [2:0]                err_n
);
  import tse_pkg::*;

  tse_core_s   core_ff;
  tse_core_s   nxt_core;
  tse_sticky_s stk_ff;
  tse_sticky_s nxt_stk;

  logic             wr;
  logic             rd;
  logic             latch_now;
  logic             old_above_lo;
  logic             new_above_lo;
  logic             old_above_hi;
  logic             new_above_hi;
  logic             low_evt;
  logic             high_evt;
  logic             pin_active;
  logic [15:0]      low_word;
  logic [15:0]      high_word;
  logic [CNT_W-1:0] last_cnt;
  logic [CNT_W-1:0] win;

  assign last_cnt = CNT_W'(INTERVAL_CYCLES - 1);

  always_comb begin
    nxt_core = core_ff;
    nxt_stk  = stk_ff;
    wr = cfg_req.req & cfg_req.we;
    rd = cfg_req.req & ~cfg_req.we;
    low_word  = {7'h00, stk_ff.low_event_flag, stk_ff.low_event_temperature};
    high_word = {7'h00, stk_ff.high_event_flag, stk_ff.high_event_temperature};

    // read path, unmapped and reserved bits read zero
    nxt_core.rsp.rvalid = rd;
    nxt_core.rsp.rdata  = BYTE_ZERO;
    if (rd) begin
      case (cfg_req.addr)
        ADDR_SENSOR_OUT:  nxt_core.rsp.rdata = core_ff.sensor_output_value;
        ADDR_LOW_THR:     nxt_core.rsp.rdata = core_ff.low_threshold;
        ADDR_HIGH_THR:    nxt_core.rsp.rdata = core_ff.high_threshold;
        ADDR_LOW_STS_B0:  nxt_core.rsp.rdata = low_word[7:0];
        ADDR_LOW_STS_B1:  nxt_core.rsp.rdata = low_word[15:8];
        ADDR_HIGH_STS_B0: nxt_core.rsp.rdata = high_word[7:0];
        ADDR_HIGH_STS_B1: nxt_core.rsp.rdata = high_word[15:8];
        ADDR_EVENT_MASK: begin
          nxt_core.rsp.rdata[MASK_LOW_BIT]  = core_ff.low_event_mask;
          nxt_core.rsp.rdata[MASK_HIGH_BIT] = core_ff.high_event_mask;
        end
        ADDR_EVENT_ROUTE: nxt_core.rsp.rdata[ROUTE_LSB +: 2] = core_ff.event_pin_select;
        ADDR_SENSOR_CTRL: begin
          nxt_core.rsp.rdata[CTRL_EN_BIT]    = stk_ff.sensor_enable;
          nxt_core.rsp.rdata[CTRL_EVLOG_BIT] = core_ff.event_logic_enable;
          nxt_core.rsp.rdata[CTRL_LATCH_BIT] = core_ff.latch_enable;
        end
        default: nxt_core.rsp.rdata = BYTE_ZERO;
      endcase
    end

    // write path, status fields are write-one-to-clear
    if (wr) begin
      case (cfg_req.addr)
        ADDR_LOW_THR:  nxt_core.low_threshold  = cfg_req.wdata;
        ADDR_HIGH_THR: nxt_core.high_threshold = cfg_req.wdata;
        ADDR_LOW_STS_B0: begin
          nxt_stk.low_event_temperature = stk_ff.low_event_temperature & ~cfg_req.wdata;
        end
        ADDR_LOW_STS_B1: begin
          if (cfg_req.wdata[FLAG_BYTE_BIT]) begin
            nxt_stk.low_event_flag = 1'b0;
          end
        end
        ADDR_HIGH_STS_B0: begin
          nxt_stk.high_event_temperature = stk_ff.high_event_temperature & ~cfg_req.wdata;
        end
        ADDR_HIGH_STS_B1: begin
          if (cfg_req.wdata[FLAG_BYTE_BIT]) begin
            nxt_stk.high_event_flag = 1'b0;
          end
        end
        ADDR_EVENT_MASK: begin
          nxt_core.low_event_mask  = cfg_req.wdata[MASK_LOW_BIT];
          nxt_core.high_event_mask = cfg_req.wdata[MASK_HIGH_BIT];
        end
        ADDR_EVENT_ROUTE: nxt_core.event_pin_select = cfg_req.wdata[ROUTE_LSB +: 2];
        ADDR_SENSOR_CTRL: begin
          nxt_stk.sensor_enable       = cfg_req.wdata[CTRL_EN_BIT];
          nxt_core.event_logic_enable = cfg_req.wdata[CTRL_EVLOG_BIT];
          nxt_core.latch_enable       = cfg_req.wdata[CTRL_LATCH_BIT];
        end
        default: nxt_core.rsp.rvalid = rd;
      endcase
    end

    // converter schedule, long first window then short periodic windows
    case (core_ff.sch)
      TSE_SCH_OFF: begin
        if (stk_ff.sensor_enable) begin
          nxt_core.sch = TSE_SCH_FIRST;
          nxt_core.cnt = CNT_ZERO;
        end
      end
      TSE_SCH_FIRST, TSE_SCH_RUN: begin
        if (!stk_ff.sensor_enable) begin
          nxt_core.sch = TSE_SCH_OFF;
          nxt_core.cnt = CNT_ZERO;
        end else if (core_ff.cnt == last_cnt) begin
          nxt_core.sch = TSE_SCH_RUN;
          nxt_core.cnt = CNT_ZERO;
        end else begin
          nxt_core.cnt = core_ff.cnt + CNT_ONE;
        end
      end
      default: begin
        nxt_core.sch = TSE_SCH_OFF;
        nxt_core.cnt = CNT_ZERO;
      end
    endcase
    win = (nxt_core.sch == TSE_SCH_FIRST) ? FIRST_WIN_CYC : RUN_WIN_CYC;
    nxt_core.conv_active = (nxt_core.sch != TSE_SCH_OFF) && (nxt_core.cnt < win);

    // sample latch and threshold crossing
    latch_now    = core_ff.conv_active & stk_ff.sensor_enable;
    old_above_lo = core_ff.sensor_output_value >= core_ff.low_threshold;
    new_above_lo = adc_code >= core_ff.low_threshold;
    old_above_hi = core_ff.sensor_output_value >= core_ff.high_threshold;
    new_above_hi = adc_code >= core_ff.high_threshold;
    low_evt  = latch_now & core_ff.sample_valid & core_ff.event_logic_enable
               & (old_above_lo != new_above_lo);
    high_evt = latch_now & core_ff.sample_valid & core_ff.event_logic_enable
               & (old_above_hi != new_above_hi);
    if (latch_now) begin
      nxt_core.sensor_output_value = adc_code;
      nxt_core.sample_valid        = 1'b1;
    end else if (!stk_ff.sensor_enable) begin
      nxt_core.sample_valid = 1'b0;
    end

    // events win over a clear in the same cycle, masks play no part here
    if (low_evt) begin
      nxt_stk.low_event_flag        = 1'b1;
      nxt_stk.low_event_temperature = adc_code;
    end
    if (high_evt) begin
      nxt_stk.high_event_flag        = 1'b1;
      nxt_stk.high_event_temperature = adc_code;
    end

    // error pin, one steered pin shared by both events
    pin_active = core_ff.event_logic_enable
                 & ((stk_ff.low_event_flag & ~core_ff.low_event_mask)
                    | (stk_ff.high_event_flag & ~core_ff.high_event_mask));
    nxt_core.err_n = PINS_IDLE;
    if (pin_active && core_ff.event_pin_select != ROUTE_RSVD) begin
      nxt_core.err_n[core_ff.event_pin_select] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      core_ff <= CORE_RST;
    end else if (ce) begin
      core_ff <= nxt_core;
    end
  end

  // sticky state ignores hard reset
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      stk_ff <= STICKY_RST;
    end else if (ce) begin
      stk_ff <= nxt_stk;
    end
  end

  assign cfg_rsp     = core_ff.rsp;
  assign conv_active = core_ff.conv_active;
  assign err_n       = core_ff.err_n;

  // checks
  chk_low_flag_set: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && low_evt) |=> stk_ff.low_event_flag)
    else $error("low event did not set low flag");

  chk_low_temp_rec: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && low_evt) |=> stk_ff.low_event_temperature == $past(adc_code))
    else $error("low temperature not recorded");

  chk_high_flag_set: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && high_evt) |=> stk_ff.high_event_flag)
    else $error("high event did not set high flag");

  chk_high_temp_rec: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && high_evt) |=> stk_ff.high_event_temperature == $past(adc_code))
    else $error("high temperature not recorded");

  chk_overwrite_temp: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && stk_ff.low_event_flag && low_evt) |=>
      stk_ff.low_event_temperature == core_ff.sensor_output_value)
    else $error("repeat crossing did not overwrite temperature");

  chk_zero_write: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && wr && cfg_req.addr == ADDR_LOW_STS_B1 && !cfg_req.wdata[FLAG_BYTE_BIT])
      |=> stk_ff.low_event_flag == $past(stk_ff.low_event_flag) || $past(low_evt))
    else $error("zero write changed low flag");

  chk_mask_block: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && core_ff.low_event_mask && !stk_ff.high_event_flag) |=> err_n == PINS_IDLE)
    else $error("masked low event reached a pin");

  chk_mask_high: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && core_ff.high_event_mask && !stk_ff.low_event_flag) |=> err_n == PINS_IDLE)
    else $error("masked high event reached a pin");

  chk_route_pin: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && pin_active && core_ff.event_pin_select == 2'h1) |=> err_n == 3'h5)
    else $error("event not steered to pin 1");

  chk_route_rsvd: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && core_ff.event_pin_select == ROUTE_RSVD) |=> err_n == PINS_IDLE)
    else $error("reserved steering drove a pin");

  chk_hold_disabled: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && !stk_ff.sensor_enable) |=> $stable(core_ff.sensor_output_value))
    else $error("sensor output changed while disabled");

  chk_latch_active: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && conv_active && stk_ff.sensor_enable) |=>
      core_ff.sensor_output_value == $past(adc_code))
    else $error("readout not latched while converter active");

  chk_run_window: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && core_ff.sch == TSE_SCH_RUN && core_ff.cnt == RUN_WIN_CYC) |-> !conv_active)
    else $error("periodic window longer than 64 clocks");

  chk_evlog_off: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && !core_ff.event_logic_enable && !wr) |=> !$rose(stk_ff.low_event_flag)
      && !$rose(stk_ff.high_event_flag))
    else $error("event raised with event logic disabled");

  chk_pin_release: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && !stk_ff.low_event_flag && !stk_ff.high_event_flag) |=> err_n == PINS_IDLE)
    else $error("pin held with no flag set");

  chk_overwrite_high: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && stk_ff.high_event_flag && high_evt) |=>
      stk_ff.high_event_temperature == $past(adc_code))
    else $error("repeat high crossing did not overwrite temperature");

  chk_high_zero_write: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && wr && cfg_req.addr == ADDR_HIGH_STS_B1 && !cfg_req.wdata[FLAG_BYTE_BIT])
      |=> stk_ff.high_event_flag == $past(stk_ff.high_event_flag) || $past(high_evt))
    else $error("zero write changed high flag");

  chk_low_clear: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && wr && cfg_req.addr == ADDR_LOW_STS_B1 && cfg_req.wdata[FLAG_BYTE_BIT] && !low_evt)
      |=> !stk_ff.low_event_flag)
    else $error("write one did not clear low flag");

  chk_high_clear: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && wr && cfg_req.addr == ADDR_HIGH_STS_B1 && cfg_req.wdata[FLAG_BYTE_BIT] && !high_evt)
      |=> !stk_ff.high_event_flag)
    else $error("write one did not clear high flag");

  chk_mask_status: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && core_ff.low_event_mask && low_evt) |=> stk_ff.low_event_flag)
    else $error("low mask blocked the status flag");

  chk_route_pin0: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && pin_active && core_ff.event_pin_select == 2'h0) |=> err_n == 3'h6)
    else $error("event not steered to pin 0");

  chk_route_pin2: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && pin_active && core_ff.event_pin_select == 2'h2) |=> err_n == 3'h3)
    else $error("event not steered to pin 2");

  chk_shared_pin: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && pin_active && core_ff.event_pin_select != ROUTE_RSVD) |=> $onehot(~err_n))
    else $error("events drove more than one pin");

  chk_conv_off: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && !stk_ff.sensor_enable) |=> !conv_active)
    else $error("converter active while sensor disabled");

  chk_first_window: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && core_ff.sch == TSE_SCH_FIRST && core_ff.cnt == FIRST_WIN_CYC) |-> !conv_active)
    else $error("first window longer than 4096 clocks");

  chk_run_open: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && core_ff.sch == TSE_SCH_RUN && core_ff.cnt < RUN_WIN_CYC) |-> conv_active)
    else $error("periodic window shorter than 64 clocks");

  chk_low_thr_write: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && wr && cfg_req.addr == ADDR_LOW_THR) |=>
      core_ff.low_threshold == $past(cfg_req.wdata))
    else $error("low threshold write lost");

  chk_high_thr_write: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && wr && cfg_req.addr == ADDR_HIGH_THR) |=>
      core_ff.high_threshold == $past(cfg_req.wdata))
    else $error("high threshold write lost");

  chk_evlog_pin: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && !core_ff.event_logic_enable) |=> err_n == PINS_IDLE)
    else $error("pin driven with event logic disabled");

  chk_same_sample: assert property (@(posedge clk) disable iff (!rstn || !por_n)
    (ce && core_ff.sensor_output_value == adc_code) |=> !$rose(stk_ff.low_event_flag)
      && !$rose(stk_ff.high_event_flag))
    else $error("event raised without a sample change");

endmodule

// *** tb/tse_thermal_event_tb.sv ***
// tse_thermal_event_tb: directed bench for the thermal event block.
// assumes the byte-wide config port of the notes and a shortened interval.
`timescale 1ns/100ps
module tse_thermal_event_tb;
  import tse_pkg::*;
  localparam int IVL = 5000;
  logic         clk;
  logic         rstn;
  logic         por_n;
  logic         ce;
  tse_cfg_req_s cfg_req;
  tse_cfg_rsp_s cfg_rsp;
  logic [7:0]   adc_code;
  logic         conv_active;
  logic [2:0]   err_n;
  int           fails;
  int           n_checks;

  tse_thermal_event #(.INTERVAL_CYCLES(IVL)) DUT (
    .clk(clk), .rstn(rstn), .por_n(por_n), .ce(ce), .cfg_req(cfg_req),
    .cfg_rsp(cfg_rsp), .adc_code(adc_code), .conv_active(conv_active), .err_n(err_n));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    cfg_req = '{req: 1'b1, we: 1'b1, addr: a, wdata: d};
    cyc(1);
    cfg_req = '0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    cyc(1);
    cfg_req = '{req: 1'b1, we: 1'b0, addr: a, wdata: 8'h00};
    cyc(1);
    cfg_req = '0;
    chk("rvalid", 1'b1, cfg_rsp.rvalid);
    chk($sformatf("reg %h", a), exp, cfg_rsp.rdata);
  endtask

  task automatic set_adc(input logic [7:0] v);
    adc_code = v;
    cyc(4);
  endtask

  task automatic wait_lvl(input logic lvl, output int n);
    n = 0;
    while (conv_active !== lvl && n < 6000) begin
      cyc(1);
      n++;
    end
    if (n >= 6000) begin
      fails++;
      $display("BAD conv_active wait expected %0h seen timeout", lvl);
      summarize();
    end
  endtask

  task automatic t_reset();
    rc(ADDR_LOW_THR, 8'hB4);
    rc(ADDR_HIGH_THR, 8'hC8);
    rc(ADDR_EVENT_MASK, 8'h00);
    rc(ADDR_EVENT_ROUTE, 8'h00);
    rc(ADDR_SENSOR_CTRL, 8'h00);
    rc(ADDR_LOW_STS_B1, 8'h00);
    rc(8'hF0, 8'h00);
    chk("err_n", 3'b111, err_n);
    $display("test reset done");
  endtask

  task automatic t_events();
    wr(ADDR_SENSOR_CTRL, 8'h07);
    cyc(10);
    rc(ADDR_SENSOR_OUT, 8'h0A);
    chk("err_n", 3'b111, err_n);
    set_adc(8'hB5);
    rc(ADDR_LOW_STS_B1, 8'h01);
    rc(ADDR_LOW_STS_B0, 8'hB5);
    chk("err_n", 3'b110, err_n);
    set_adc(8'hC9);
    rc(ADDR_HIGH_STS_B1, 8'h01);
    rc(ADDR_HIGH_STS_B0, 8'hC9);
    set_adc(8'hC0);
    rc(ADDR_HIGH_STS_B0, 8'hC0);
    $display("test events done");
  endtask

  task automatic t_clear_route();
    wr(ADDR_LOW_STS_B1, 8'h00);
    rc(ADDR_LOW_STS_B1, 8'h01);
    wr(ADDR_LOW_STS_B1, 8'h01);
    rc(ADDR_LOW_STS_B1, 8'h00);
    wr(ADDR_LOW_STS_B0, 8'hFF);
    rc(ADDR_LOW_STS_B0, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_EVENT_ROUTE, s[7:0]);
      cyc(3);
      chk("err_n route", (s == 3) ? 3'b111 : 3'(~(3'b001 << s)), err_n);
    end
    wr(ADDR_EVENT_ROUTE, 8'h00);
    wr(ADDR_EVENT_MASK, 8'h01);
    cyc(3);
    chk("err_n high mask", 3'b111, err_n);
    wr(ADDR_HIGH_STS_B1, 8'h00);
    rc(ADDR_HIGH_STS_B1, 8'h01);
    wr(ADDR_HIGH_STS_B1, 8'h01);
    wr(ADDR_EVENT_MASK, 8'h00);
    cyc(3);
    chk("err_n released", 3'b111, err_n);
    $display("test clear and route done");
  endtask

  task automatic t_low_mask();
    wr(ADDR_EVENT_MASK, 8'h02);
    set_adc(8'hA0);
    rc(ADDR_LOW_STS_B1, 8'h01);
    rc(ADDR_LOW_STS_B0, 8'hA0);
    chk("err_n low mask", 3'b111, err_n);
    wr(ADDR_EVENT_MASK, 8'h00);
    cyc(3);
    chk("err_n low unmask", 3'b110, err_n);
    $display("test low mask done");
  endtask

  task automatic t_sticky();
    wr(ADDR_LOW_THR, 8'h20);
    rc(ADDR_LOW_THR, 8'h20);
    wr(ADDR_HIGH_THR, 8'h30);
    rc(ADDR_HIGH_THR, 8'h30);
    ce = 1'b0;
    wr(ADDR_LOW_THR, 8'h55);
    ce = 1'b1;
    rc(ADDR_LOW_THR, 8'h20);
    rstn = 1'b0;
    cyc(2);
    rstn = 1'b1;
    rc(ADDR_LOW_STS_B1, 8'h01);
    rc(ADDR_LOW_STS_B0, 8'hA0);
    rc(ADDR_SENSOR_CTRL, 8'h02);
    rc(ADDR_LOW_THR, 8'hB4);
    rc(ADDR_HIGH_THR, 8'hC8);
    $display("test sticky done");
  endtask

  task automatic t_evlog_off();
    wr(ADDR_LOW_STS_B1, 8'h01);
    set_adc(8'hA0);
    set_adc(8'hC9);
    rc(ADDR_LOW_STS_B1, 8'h00);
    rc(ADDR_HIGH_STS_B1, 8'h00);
    chk("err_n", 3'b111, err_n);
    wr(ADDR_SENSOR_CTRL, 8'h00);
    set_adc(8'h33);
    rc(ADDR_SENSOR_OUT, 8'hC9);
    chk("conv_active off", 1'b0, conv_active);
    $display("test disable done");
  endtask

  task automatic t_sched();
    int g;
    int hi;
    int g2;
    wr(ADDR_SENSOR_CTRL, 8'h02);
    wait_lvl(1'b1, g);
    chk("enable latency", 1, g);
    wait_lvl(1'b0, hi);
    chk("first window", 4096, hi);
    rc(ADDR_SENSOR_OUT, 8'h33);
    wait_lvl(1'b1, g);
    wait_lvl(1'b0, hi);
    chk("run window", 64, hi);
    wait_lvl(1'b1, g2);
    chk("interval", IVL, hi + g2);
    $display("test schedule done");
  endtask

  initial begin
    rstn = 1'b0;
    por_n = 1'b0;
    ce = 1'b1;
    cfg_req = '0;
    adc_code = 8'h0A;
    fails = 0;
    n_checks = 0;
    repeat (12) @(posedge clk);
    #1;
    rstn = 1'b1;
    por_n = 1'b1;
    t_reset();
    t_events();
    t_clear_route();
    t_low_mask();
    t_sticky();
    t_evlog_off();
    t_sched();
    summarize();
  end
endmodule
